// ### ebctd_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the carrier timer
// Assumes: 32-bit AXI4-Lite data, one aligned word per register, 8-bit byte address
// Notes: definitions only
`ifndef EBCTD_DEFS_SVH
`define EBCTD_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define EBCTD_OFS_TIMER8_CONTROL 8'h00
`define EBCTD_OFS_SHARED_CONTROL 8'h04
`define EBCTD_OFS_HIGH_RELOAD 8'h08
`define EBCTD_OFS_LOW_RELOAD 8'h0c
`define EBCTD_OFS_CAPTURE_HIGH 8'h10
`define EBCTD_OFS_CAPTURE_LOW 8'h14
`define EBCTD_OFS_INT_MASK 8'h18

////////////////////////////////////////////////////////////////////////////////
// timer8_control fields
`define EBCTD_T8_ENABLE 7
`define EBCTD_T8_SINGLE 6
`define EBCTD_T8_TIMEOUT 5
`define EBCTD_T8_TOUT_IE 1
// shared_timer_control fields
`define EBCTD_SH_MODE 7
`define EBCTD_SH_INSEL 6
`define EBCTD_SH_EDGE_HI 5
`define EBCTD_SH_EDGE_LO 4
`define EBCTD_SH_INIT_RISE 1
`define EBCTD_SH_FALL 0
// interrupt_mask_register fields
`define EBCTD_IM_CAP_PIN 2
`define EBCTD_IM_CAPTURE 1
`define EBCTD_IM_COUNTER 0

////////////////////////////////////////////////////////////////////////////////
// reset values, codes and timing
`define EBCTD_REG_RESET 8'h00
`define EBCTD_EDGE_FALL 2'h0
`define EBCTD_EDGE_RISE 2'h1
`define EBCTD_EDGE_BOTH 2'h2
`define EBCTD_RESP_OKAY 2'h0
`define EBCTD_RESP_SLVERR 2'h2
`define EBCTD_TERMINAL 8'h01
`define EBCTD_TICK_DIV 8'h02

`endif

// ### ebctd_pkg.sv
// Purpose: types shared by the carrier timer files
// Assumes: nothing beyond SystemVerilog packed types
// Notes: constants live in ebctd_defs.svh
package ebctd_pkg;

  // counter sequencer, gray along idle -> wait -> run -> stop
  typedef enum logic [1:0] {
    EBCTD_IDLE = 2'b00,
    EBCTD_WAIT = 2'b01,
    EBCTD_RUN = 2'b11,
    EBCTD_STOP = 2'b10
  } ebctd_fsm_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } ebctd_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ebctd_axi_resp_t;

  typedef struct packed {
    logic prev;
    logic armed;
  } ebctd_edge_state_t;

  typedef struct packed {
    ebctd_axi_resp_t axi;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_be;
    logic en_sw;
    logic single;
    logic tout;
    logic tie;
    logic mode;
    logic insel;
    logic [1:0] edge_sel;
    logic init;
    logic rise_f;
    logic fall_f;
    logic [7:0] high_reload;
    logic [7:0] low_reload;
    logic [7:0] capture_high;
    logic [7:0] capture_low;
    logic m_cap_pin;
    logic m_cap;
    logic m_cnt;
    logic [7:0] div;
    logic run;
    logic [2:0] clr_pend;
    ebctd_fsm_t fsm;
    logic [7:0] cnt;
    logic out;
    logic first_done;
    logic cnt_irq;
    logic cap_irq;
    logic pin_irq;
  } ebctd_state_t;

endpackage

// ### ebctd_edge.sv
// Purpose: edge finder for the selected demodulator input
// Assumes: input is synchronous to aclk
// Notes: first sample after reset only arms, so no false edge appears
`timescale 1ns/1ps
`default_nettype none
module ebctd_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sig,
  output logic rise,
  output logic fall
);
  import ebctd_pkg::*;

  ebctd_edge_state_t s_q, s_d;

  // compare the pin with its last sample
  always_comb begin
    s_d = s_q;
    s_d.prev = sig;
    s_d.armed = 1'b1;
    rise = s_q.armed & sig & ~s_q.prev;
    fall = s_q.armed & ~sig & s_q.prev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // ebctd_edge
`default_nettype wire

// ### ebctd_top.sv
// Purpose: 8-bit carrier timer with transmit and demodulation modes, AXI4-Lite registers
// Assumes: pins synchronous to aclk; counter clock is aclk divided by TICK_DIV
// Notes:
// Overview of operation
// - demod input select bit picks port2 bit0 or port3 bit1 as measured input.
// - port3 bit1 captures also raise capture-pin interrupt unless mask bit D2 clear.
// - enabling the timer in transmit mode drives toggle output to the initial level bit D1.
// - transmit enable loads low reload for initial level 0, high reload for 1; demod enable loads low reload.
// - single-pass counts to zero, stops, toggles, sets timeout, interrupts if enabled.
// - modulo-N first terminal only toggles; next one toggles, sets timeout, interrupts.
// - modulo-N reloads low or high by new output level, repeating forever.
// - reload registers writable anytime; new value used at next load.
// - initial count zero steps to FFh then FEh, a full 256-state count.
// - wrap from zero to FFh is no timeout, no status, no interrupt.
// - stop and status clear act one counter clock later; software uses two writes.
// - demod counting starts at first edge of polarity chosen by bits D5:D4.
// - later qualifying edges store complemented count into a capture register.
// - mode bit zero selects transmit, one selects demodulation.
// - capture mask bit allows interrupt on every capture in demodulation.
// - counter mask bit allows interrupt on eight-bit timer timeout.
`timescale 1ns/1ps
`default_nettype none
`include "ebctd_defs.svh"
module ebctd_top #(
  parameter logic [7:0] TICK_DIV = `EBCTD_TICK_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ebctd_pkg::ebctd_axi_req_t axi_req,
  output ebctd_pkg::ebctd_axi_resp_t axi_resp,
  input wire logic port2_bit0_input,
  input wire logic port3_bit1_input,
  output logic timer_toggle_output,
  output logic counter_irq,
  output logic capture_irq,
  output logic capture_pin_interrupt
);
  import ebctd_pkg::*;

  // every piece of state outside the edge finder lives in one packed struct: one always_comb builds the next copy
  // and one always_ff registers it, so a field cannot end up with a second driver
  // by accident. the cost is a wide flop vector that carries some idle fields,
  // but it keeps reset uniform: one clear of the whole struct gives the documented zeros.

  ebctd_state_t s_q, s_d;
  logic sel_in;
  logic edge_rise;
  logic edge_fall;

  ////////////////////////////////////////////////////////////////////////////////
  // input selection and edge finding
  assign sel_in = s_q.insel ? port2_bit0_input : port3_bit1_input;

  ebctd_edge u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig(sel_in),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets give slverr
  // bit 32 of the returned word is the hit flag, used only for the response code.
  // in demodulation mode the two low bits of the shared control word show the edge
  // flags instead of the initial levels, so software sees what the demodulator saw.
  function automatic logic [32:0] rd_word(input ebctd_state_t s, input logic [7:0] a);
    logic [7:0] v;
    logic hit;
    v = 8'h00;
    hit = 1'b1;
    case (a)
      `EBCTD_OFS_TIMER8_CONTROL: begin
        v[`EBCTD_T8_ENABLE] = s.en_sw;
        v[`EBCTD_T8_SINGLE] = s.single;
        v[`EBCTD_T8_TIMEOUT] = s.tout;
        v[`EBCTD_T8_TOUT_IE] = s.tie;
      end
      `EBCTD_OFS_SHARED_CONTROL: begin
        v[`EBCTD_SH_MODE] = s.mode;
        v[`EBCTD_SH_INSEL] = s.insel;
        v[`EBCTD_SH_EDGE_HI:`EBCTD_SH_EDGE_LO] = s.edge_sel;
        v[`EBCTD_SH_INIT_RISE] = s.mode ? s.rise_f : s.init;
        v[`EBCTD_SH_FALL] = s.mode & s.fall_f;
      end
      `EBCTD_OFS_HIGH_RELOAD: v = s.high_reload;
      `EBCTD_OFS_LOW_RELOAD: v = s.low_reload;
      `EBCTD_OFS_CAPTURE_HIGH: v = s.capture_high;
      `EBCTD_OFS_CAPTURE_LOW: v = s.capture_low;
      `EBCTD_OFS_INT_MASK: begin
        v[`EBCTD_IM_CAP_PIN] = s.m_cap_pin;
        v[`EBCTD_IM_CAPTURE] = s.m_cap;
        v[`EBCTD_IM_COUNTER] = s.m_cnt;
      end
      default: hit = 1'b0;
    endcase
    return {hit, 24'h000000, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic tick;
    logic wr_go;
    logic wr_hit;
    logic [32:0] rd;
    logic qual;
    logic tog;
    tick = 1'b0;
    wr_go = 1'b0;
    wr_hit = 1'b1;
    rd = '0;
    qual = 1'b0;
    tog = 1'b0;
    s_d = s_q;
    s_d.cap_irq = 1'b0;
    s_d.pin_irq = 1'b0;

    // counter clock enable from the divider
    tick = (s_q.div >= TICK_DIV - 8'h01);
    s_d.div = tick ? 8'h00 : s_q.div + 8'h01;

    // write address and data are taken independently, in either order
    // each beat is parked in its own holding slot, so a master that offers data
    // before the address, or the other way round, still completes one write.
    if (s_q.axi.awready && axi_req.awvalid) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (s_q.axi.wready && axi_req.wvalid) begin
      s_d.w_full = 1'b1;
      s_d.w_data = axi_req.wdata[7:0];
      s_d.w_be = axi_req.wstrb[0];
    end
    if (s_q.axi.bvalid && axi_req.bready) begin
      s_d.axi.bvalid = 1'b0;
    end
    wr_go = s_d.aw_full && s_d.w_full && !s_d.axi.bvalid;

    // register writes; only byte lane 0 carries data
    // reload writes land at once but are only used at the next load into the counter,
    // so a write landing on the very tick of a load is a software hazard, not a
    // hardware one: the counter takes whichever value stood in the previous cycle.
    if (wr_go) begin
      case (s_d.aw_addr)
        `EBCTD_OFS_TIMER8_CONTROL: if (s_d.w_be) begin
          s_d.en_sw = s_d.w_data[`EBCTD_T8_ENABLE];
          s_d.single = s_d.w_data[`EBCTD_T8_SINGLE];
          s_d.tie = s_d.w_data[`EBCTD_T8_TOUT_IE];
          s_d.clr_pend[0] = s_q.clr_pend[0] | s_d.w_data[`EBCTD_T8_TIMEOUT];
        end
        `EBCTD_OFS_SHARED_CONTROL: if (s_d.w_be) begin
          s_d.mode = s_d.w_data[`EBCTD_SH_MODE];
          s_d.insel = s_d.w_data[`EBCTD_SH_INSEL];
          s_d.edge_sel = s_d.w_data[`EBCTD_SH_EDGE_HI:`EBCTD_SH_EDGE_LO];
          if (!s_d.w_data[`EBCTD_SH_MODE]) begin
            s_d.init = s_d.w_data[`EBCTD_SH_INIT_RISE];
          end else begin
            s_d.clr_pend[1] = s_q.clr_pend[1] | s_d.w_data[`EBCTD_SH_INIT_RISE];
            s_d.clr_pend[2] = s_q.clr_pend[2] | s_d.w_data[`EBCTD_SH_FALL];
          end
        end
        `EBCTD_OFS_HIGH_RELOAD: if (s_d.w_be) s_d.high_reload = s_d.w_data;
        `EBCTD_OFS_LOW_RELOAD: if (s_d.w_be) s_d.low_reload = s_d.w_data;
        `EBCTD_OFS_INT_MASK: if (s_d.w_be) begin
          s_d.m_cap_pin = s_d.w_data[`EBCTD_IM_CAP_PIN];
          s_d.m_cap = s_d.w_data[`EBCTD_IM_CAPTURE];
          s_d.m_cnt = s_d.w_data[`EBCTD_IM_COUNTER];
        end
        `EBCTD_OFS_CAPTURE_HIGH, `EBCTD_OFS_CAPTURE_LOW: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.axi.bvalid = 1'b1;
      s_d.axi.bresp = wr_hit ? `EBCTD_RESP_OKAY : `EBCTD_RESP_SLVERR;
    end
    // one write in flight: hold off new beats until the response is taken
    s_d.axi.awready = !s_d.aw_full && !s_d.axi.bvalid;
    s_d.axi.wready = !s_d.w_full && !s_d.axi.bvalid;

    // read channel: data one cycle after the address is taken
    if (s_q.axi.rvalid && axi_req.rready) begin
      s_d.axi.rvalid = 1'b0;
    end
    if (s_q.axi.arready && axi_req.arvalid) begin
      rd = rd_word(s_q, axi_req.araddr);
      s_d.axi.rvalid = 1'b1;
      s_d.axi.rdata = rd[31:0];
      s_d.axi.rresp = rd[32] ? `EBCTD_RESP_OKAY : `EBCTD_RESP_SLVERR;
    end
    s_d.axi.arready = !s_d.axi.rvalid;

    // counter clock: stop and clears land one tick after the write
    // the enable is sampled into run only on a tick, which gives the one counter
    // clock of delay that software must allow before a separate status clear.
    // a timeout that falls on the same tick as a pending clear is set again below,
    // so the clear never hides an event that software has not yet seen.
    if (tick) begin
      if (s_q.clr_pend[0]) s_d.tout = 1'b0;
      if (s_q.clr_pend[1]) s_d.rise_f = 1'b0;
      if (s_q.clr_pend[2]) s_d.fall_f = 1'b0;
      s_d.clr_pend = s_d.clr_pend & ~s_q.clr_pend;
      s_d.run = s_q.en_sw;
      if (!s_q.run && s_q.en_sw) begin
        // start: transmit loads by initial level, demod waits for an edge
        s_d.first_done = 1'b0;
        if (!s_q.mode) begin
          s_d.out = s_q.init;
          s_d.cnt = s_q.init ? s_q.high_reload : s_q.low_reload;
          s_d.fsm = EBCTD_RUN;
        end else begin
          s_d.cnt = s_q.low_reload;
          s_d.fsm = EBCTD_WAIT;
        end
      end else if (s_q.run && !s_q.en_sw) begin
        s_d.fsm = EBCTD_IDLE;
      end else if (s_q.run && s_q.fsm == EBCTD_RUN) begin
        if (!s_q.mode && s_q.cnt == `EBCTD_TERMINAL) begin
          // terminal count: the next step would reach zero
          tog = ~s_q.out;
          s_d.out = tog;
          if (s_q.single) begin
            s_d.cnt = 8'h00;
            s_d.fsm = EBCTD_STOP;
            s_d.tout = 1'b1;
          end else begin
            s_d.cnt = tog ? s_q.high_reload : s_q.low_reload;
            if (s_q.first_done) s_d.tout = 1'b1;
            s_d.first_done = ~s_q.first_done;
          end
        end else begin
          // zero wraps to ffh silently, giving 256 states
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
    end

    // demodulation edges are seen every aclk, not only on ticks
    // the first qualifying edge only starts the count; later ones store the
    // complemented count, so a longer interval reads back as a larger value.
    // limitation: edges closer together than one aclk cannot be resolved.
    case (s_q.edge_sel)
      `EBCTD_EDGE_FALL: qual = edge_fall;
      `EBCTD_EDGE_RISE: qual = edge_rise;
      `EBCTD_EDGE_BOTH: qual = edge_rise | edge_fall;
      default: qual = 1'b0;
    endcase
    if (s_q.mode && s_q.run && s_q.en_sw && qual) begin
      if (edge_rise) s_d.rise_f = 1'b1;
      if (edge_fall) s_d.fall_f = 1'b1;
      if (s_q.fsm == EBCTD_WAIT) begin
        s_d.fsm = EBCTD_RUN;
      end else if (s_q.fsm == EBCTD_RUN) begin
        if (edge_rise) begin
          s_d.capture_high = ~s_q.cnt;
        end else begin
          s_d.capture_low = ~s_q.cnt;
        end
        s_d.cap_irq = s_q.m_cap;
        s_d.pin_irq = !s_q.insel && s_q.m_cap_pin;
      end
    end

    // timeout request level follows status, enable and mask
    // it is a level, not a pulse: it stays up until software clears the status
    // bit, drops the enable or closes the mask.
    s_d.cnt_irq = s_d.tout && s_d.tie && s_d.m_cnt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register, synchronous reset
  // a synchronous reset keeps the whole block in one timing domain; the reset
  // must therefore be held across at least one rising edge of aclk.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // all outputs straight from the state register
  // no logic sits between a flop and a pin, so the outputs are free of glitches
  // and the bus answers carry one cycle of latency by construction.
  assign axi_resp = s_q.axi;
  assign timer_toggle_output = s_q.out;
  assign counter_irq = s_q.cnt_irq;
  assign capture_irq = s_q.cap_irq;
  assign capture_pin_interrupt = s_q.pin_irq;
endmodule // ebctd_top
`default_nettype wire

// ### ebctd_assertions.sv
// Purpose: bus handshake and capture timing checks on the carrier timer top
// Assumes: one aclk domain, synchronous active-low reset
// Notes: capture pulses must follow recent pin movement
`timescale 1ns/1ps
`default_nettype none
module ebctd_assertions #(
  parameter logic [7:0] TICK_DIV = 8'h02
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ebctd_pkg::ebctd_axi_req_t axi_req,
  input wire ebctd_pkg::ebctd_axi_resp_t axi_resp,
  input wire logic port2_bit0_input,
  input wire logic port3_bit1_input,
  input wire logic timer_toggle_output,
  input wire logic counter_irq,
  input wire logic capture_irq,
  input wire logic capture_pin_interrupt
);
  import ebctd_pkg::*;
  logic [1:0] pins_q;
  logic [3:0] quiet_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles since a pin moved, saturating so it never wraps back to small
  always_ff @(posedge aclk) begin
    pins_q <= {port2_bit0_input, port3_bit1_input};
    if (!aresetn || pins_q != {port2_bit0_input, port3_bit1_input}) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_bresp_stands:
    assert property (axi_resp.bvalid && !axi_req.bready |=> axi_resp.bvalid && $stable(axi_resp.bresp))
    else $error("write response dropped before bready");
  chk_rdata_stands:
    assert property (axi_resp.rvalid && !axi_req.rready |=> axi_resp.rvalid && $stable(axi_resp.rdata))
    else $error("read data dropped before rready");
  chk_write_answer:
    assert property (axi_req.awvalid && axi_resp.awready && axi_req.wvalid && axi_resp.wready
      |=> axi_resp.bvalid) else $error("no write response one cycle after address and data");
  chk_read_answer:
    assert property (axi_req.arvalid && axi_resp.arready |=> axi_resp.rvalid)
    else $error("no read data one cycle after read address");
  chk_busy_refused:
    assert property (axi_resp.bvalid |-> !axi_resp.awready && !axi_resp.wready && 1'b1)
    else $error("write channels ready while response pending");
  chk_capture_cause:
    assert property (capture_irq |-> quiet_q < 4'h8) else $error("capture pulse without pin edge");
  chk_pin_irq_cause:
    assert property (capture_pin_interrupt |-> quiet_q < 4'h8) else $error("pin irq without edge");
  chk_capture_pulse:
    assert property ($rose(capture_irq) |=> !capture_irq) else $error("capture irq not one cycle");
  chk_reset_outputs:
    assert property ($past(aresetn) == 1'b0 |-> !timer_toggle_output && !counter_irq)
    else $error("outputs not low after reset");
endmodule // ebctd_assertions
bind ebctd_top ebctd_assertions #(.TICK_DIV(TICK_DIV)) u_ebctd_assertions (.aclk(aclk),
  .aresetn(aresetn), .axi_req(axi_req), .axi_resp(axi_resp), .port2_bit0_input(port2_bit0_input),
  .port3_bit1_input(port3_bit1_input), .timer_toggle_output(timer_toggle_output),
  .counter_irq(counter_irq), .capture_irq(capture_irq),
  .capture_pin_interrupt(capture_pin_interrupt));
`default_nettype wire

// ### ebctd_pulse_src.sv
// Purpose: external pulse source feeding one demodulator pin
// Assumes: synchronous to aclk
// Notes: line idles low when the source is off
`timescale 1ns/1ps
`default_nettype none
module ebctd_pulse_src (
  input wire logic aclk,
  input wire logic en,
  input wire logic [7:0] half,
  output logic line
);
  logic [7:0] cnt_q;
  initial begin
    line = 1'b0;
    cnt_q = 8'h00;
  end
  // square wave of half-period half; restarts low so the first edge is a rise
  always @(posedge aclk) begin
    if (!en) begin
      line <= 1'b0;
      cnt_q <= 8'h00;
    end else if (cnt_q == half - 8'h01) begin
      line <= ~line;
      cnt_q <= 8'h00;
    end else cnt_q <= cnt_q + 8'h01;
  end
endmodule // ebctd_pulse_src
`default_nettype wire

// ### ebctd_top_bench.sv
// Purpose: register-level tests of the carrier timer
// Assumes: TICK_DIV of 1, so one counter clock per aclk
// Notes: phase lengths are measured by a monitor, not by the sequence
`timescale 1ns/1ps
`default_nettype none
module ebctd_top_bench;
  import ebctd_pkg::*;
  logic aclk, aresetn, p2, p3, en2, en3, tout, cirq, capirq, pinirq, last, lv;
  ebctd_axi_req_t req;
  ebctd_axi_resp_t resp;
  int err_total, checks_done, run, n_cap, n_pin, nc, np;
  int ph[2];
  logic [31:0] rdw;
  logic [1:0] rr;
  ebctd_top #(.TICK_DIV(8'h01)) u_ebctd_top (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_resp(resp), .port2_bit0_input(p2), .port3_bit1_input(p3), .timer_toggle_output(tout),
    .counter_irq(cirq), .capture_irq(capirq), .capture_pin_interrupt(pinirq));
  ebctd_pulse_src u_p2 (.aclk(aclk), .en(en2), .half(8'h14), .line(p2));
  ebctd_pulse_src u_p3 (.aclk(aclk), .en(en3), .half(8'h14), .line(p3));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // length of the last phase at each output level, and capture pulse counts
  always @(posedge aclk) begin
    last <= tout;
    if (tout !== last) begin
      ph[last] <= run;
      run <= 1;
    end else run <= run + 1;
    n_cap <= n_cap + int'(capirq === 1'b1);
    n_pin <= n_pin + int'(pinirq === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_in(input string nm, input logic [7:0] lo, input logic [7:0] hi,
    input logic [7:0] got);
    checks_done++;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_total++;
      $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 3000) begin
      err_total++;
      $display("[FAIL] wait expected done seen timeout");
      end_sim();
    end
  endtask
  // one write, address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge aclk);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= {24'h0, d}; req.wstrb <= 4'hf; req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (req.awvalid && resp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && resp.wready) req.wvalid <= 1'b0;
    end while (resp.bvalid !== 1'b1 && n < 3000);
    req.bready <= 1'b0;
    rr = resp.bresp;
    guard(n);
  endtask
  task automatic rdr(input logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (req.arvalid && resp.arready) req.arvalid <= 1'b0;
    end while (resp.rvalid !== 1'b1 && n < 3000);
    req.rready <= 1'b0;
    rdw = resp.rdata;
    rr = resp.rresp;
    guard(n);
  endtask
  task automatic wait_out(input logic lvl);
    int n = 0;
    while (tout !== lvl && n < 3000) begin @(posedge aclk); n++; end
    guard(n);
    repeat (2) @(posedge aclk);
  endtask
  task automatic wait_cap(input int target);
    int n = 0;
    while (n_cap < target && n < 3000) begin @(posedge aclk); n++; end
    guard(n);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0; req = '0; en2 = 1'b0; en3 = 1'b0; last = 1'b0; run = 0; ph[0] = 0;
    ph[1] = 0; err_total = 0; checks_done = 0; n_cap = 0; n_pin = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, then an unmapped slot refused both ways
    for (int a = 0; a <= 24; a += 4) begin rdr(a[7:0]); chk("reset value", 32'h0, rdw); end
    rdr(8'h1c); chk("unmapped rresp", 32'h2, {30'h0, rr});
    wr(8'h1c, 8'h5a); chk("unmapped bresp", 32'h2, {30'h0, rr});
    // modulo-N: low 20h, high 10h, initial level 0
    // reload values kept clear of one, and written away from the load ticks
    wr(8'h0c, 8'h20); wr(8'h08, 8'h10); wr(8'h18, 8'h01); wr(8'h04, 8'h00); wr(8'h00, 8'h82);
    wait_out(1'b1); rdr(8'h00); chk("first terminal timeout", 32'h0, rdw[5]);
    chk("first terminal irq", 32'h0, cirq);
    wait_out(1'b0); rdr(8'h00); chk("second terminal timeout", 32'h1, rdw[5]);
    chk("counter irq", 32'h1, cirq);
    wait_out(1'b1); chk("phase difference", 32'd16, ph[0] - ph[1]);
    // new low value of zero lands at the next load only
    wr(8'h0c, 8'h00); wait_out(1'b0); wr(8'h00, 8'ha2); wait_out(1'b1);
    rdr(8'h00); chk("wrap gives no timeout", 32'h0, rdw[5]);
    chk("full count phase", 32'd240, ph[0] - ph[1]);
    // stop, then clear in a separate write
    wr(8'h00, 8'h02); wr(8'h00, 8'h22); rdr(8'h00);
    chk("cleared timeout", 32'h0, rdw[5]); chk("irq after clear", 32'h0, cirq);
    lv = tout; repeat (300) @(posedge aclk); chk("held while off", lv, tout);
    // single pass from the opposite level
    wr(8'h0c, 8'h10); wr(8'h04, {6'h0, ~lv, 1'b0}); wr(8'h00, 8'hc2);
    wait_out(~lv); wait_out(lv); rdr(8'h00);
    chk("single timeout", 32'h1, rdw[5]); chk("single irq", 32'h1, cirq);
    repeat (300) @(posedge aclk); chk("single stops", lv, tout);
    wr(8'h00, 8'h02); wr(8'h00, 8'h22);
    // demodulation on port3, rising edges
    wr(8'h08, 8'hff); wr(8'h0c, 8'hff); wr(8'h18, 8'h07); wr(8'h04, 8'h90);
    wr(8'h00, 8'h80); np = n_pin; en3 <= 1'b1; wait_cap(n_cap + 1); en3 <= 1'b0;
    rdr(8'h10); chk_in("capture high", 8'h27, 8'h29, rdw[7:0]);
    rdr(8'h14); chk("capture low untouched", 32'h0, rdw);
    chk("pin irq count", 32'd1, n_pin - np);
    // port2 selected, both edges: port3 ignored, falls go to capture low
    wr(8'h00, 8'h00); wr(8'h04, 8'he0); wr(8'h00, 8'h80); nc = n_cap; np = n_pin;
    en3 <= 1'b1; repeat (200) @(posedge aclk); en3 <= 1'b0;
    chk("unselected pin", 32'd0, n_cap - nc);
    en2 <= 1'b1; wait_cap(nc + 1); en2 <= 1'b0;
    rdr(8'h14); chk_in("capture low", 8'h13, 8'h15, rdw[7:0]);
    chk("no pin irq on port2", 32'd0, n_pin - np);
    end_sim();
  end
endmodule // ebctd_top_bench
`default_nettype wire
